// File: inc/usb_front_pkg.sv
// Purpose: shared constants for the usb front-end block
// Assumes: 8-bit special function register port, 40 MHz clock
// Notes:   charger register layouts are this block's own
package usb_front_pkg;
  // sfr addresses
  localparam logic [7:0] ADDR_INDIRECT_CORE_ADDRESS = 8'hae;
  localparam logic [7:0] ADDR_INDIRECT_CORE_DATA    = 8'haf;
  localparam logic [7:0] ADDR_TRANSCEIVER_CONTROL   = 8'hb3;
  localparam logic [7:0] ADDR_CHARGER_DETECT_CONFIG  = 8'hb4;
  localparam logic [7:0] ADDR_CHARGER_DETECT_CONTROL = 8'hb5;
  localparam logic [7:0] ADDR_CHARGER_DETECT_STATUS  = 8'hb6;
  // transceiver_control fields
  localparam int XCN_PULLUP_BIT = 7;
  localparam int XCN_XCVR_BIT   = 6;
  localparam int XCN_SPEED_BIT  = 5;
  localparam int XCN_TEST_HI    = 4;
  localparam int XCN_TEST_LO    = 3;
  localparam logic [4:0] XCN_RESET = 5'h00;
  localparam logic [1:0] TEST_NORMAL = 2'h0;
  localparam logic [1:0] TEST_DIFF1  = 2'h1;
  localparam logic [1:0] TEST_DIFF0  = 2'h2;
  localparam logic [1:0] TEST_SE0    = 2'h3;
  // indirect address fields
  localparam int ADR_BUSY_BIT = 7;
  localparam int ADR_AUTO_BIT = 6;
  localparam logic [5:0] ADR_RESET  = 6'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  // charger_detect_config: [7] vbus sense, [5:4] contact, [3] primary, [2] secondary
  localparam int CF_VBUS_SENSE_BIT = 7;
  localparam int CF_DCD_HI = 5;
  localparam int CF_DCD_LO = 4;
  localparam int CF_PRI_BIT = 3;
  localparam int CF_SEC_BIT = 2;
  localparam logic [1:0] DCD_FULL = 2'h3;
  localparam logic [7:0] CF_RESET = 8'h00;
  // charger_detect_control: [0] sequence enable
  localparam int CN_SEQ_BIT = 0;
  // charger_detect_status flags (write one to clear [7:3])
  localparam int ST_ERR_BIT  = 7;
  localparam int ST_VBUS_ON  = 6;
  localparam int ST_DCD_DONE = 5;
  localparam int ST_PRI_DONE = 4;
  localparam int ST_SEC_DONE = 3;
  localparam int ST_SDP_BIT  = 2;
  localparam int ST_DCP_BIT  = 1;
  localparam int ST_CDP_BIT  = 0;
  // timing
  localparam int CLK_HZ     = 40_000_000;
  localparam int PHASE_US   = 100;
  localparam int PHASE_CYCLES = (PHASE_US * (CLK_HZ / 1_000_000));
  localparam int CORE_READ_CYCLES = 2;
  typedef enum logic [2:0] {
    SEQ_IDLE, SEQ_CONTACT, SEQ_PRIMARY, SEQ_SECONDARY
  } seq_state_t;
endpackage

// File: design/line_sync3.sv
// Purpose: three-stage synchroniser with agreement filter
// Assumes: input is asynchronous to ref_clk_i
// Notes:   output moves only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module line_sync3 (
  input  wire logic ref_clk_i,
  input  wire logic resetn_i,
  input  wire logic async_i,
  output logic      level_o
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= async_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      level_o <= 1'b0;
    end else if (s2_reg == s3_reg) begin
      level_o <= s3_reg;
    end
  end
endmodule
`default_nettype wire

// File: design/usb_charger_detect_phy_access.sv
// Purpose: charger detect sequencer, transceiver control, indirect core port
// Assumes: sfr bus of one-cycle read/write strobes; core answers after a fixed delay
// Notes:   analog comparators are abstracted into port-type result inputs
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - sequencer waits for enable and vbus; vbus assumed present without sensing
// - phases run contact, primary, secondary, skipping disabled ones
// - each finished phase sets its done flag and clears its enable
// - vbus loss while enabled aborts the phase and sets error
// - one interrupt for vbus arrival, vbus-loss error and phase completions
// - contact field full value enables detection plus timeout
// - after primary, a status bit reports standard port found
// - after secondary, two status bits report dedicated or charging port
// - speed 0 low speed pull-up on D-, 1 full speed on D+
// - line test field selects normal or forced line drive
// - readback bit shows differential bus state while transceiver enabled
// - two readback bits show D+ and D- levels
// - 6-bit address selects target core register
// - auto-read starts next read on each data read, address kept
// - data register reads or writes the selected core register
module usb_charger_detect_phy_access (
  input  wire logic       ref_clk_i,
  input  wire logic       resetn_i,
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic [7:0] sfr_wdata_i,
  input  wire logic       sfr_wr_i,
  input  wire logic       sfr_rd_i,
  output logic      [7:0] sfr_rdata_o,
  input  wire logic       vbus_i,
  input  wire logic       dp_i,
  input  wire logic       dn_i,
  input  wire logic       contact_seen_i,
  input  wire logic       primary_charger_i,
  input  wire logic       secondary_dedicated_i,
  output logic            dp_o,
  output logic            dp_oe_o,
  output logic            dn_o,
  output logic            dn_oe_o,
  output logic            pullup_dp_o,
  output logic            pullup_dn_o,
  output logic            xcvr_suspend_o,
  output logic            full_speed_o,
  output logic            dcd_timeout_en_o,
  output logic            irq_o,
  output logic      [5:0] core_addr_o,
  output logic      [7:0] core_wdata_o,
  output logic            core_wr_o,
  output logic            core_rd_o,
  input  wire logic [7:0] core_rdata_i
);
  logic [4:0]  xcn_reg;
  logic [5:0]  adr_reg;
  logic        auto_reg;
  logic        busy_reg;
  logic [7:0]  data_reg;
  logic [7:0]  cf_reg;
  logic        seq_en_reg;
  logic [7:0]  st_reg;
  logic [7:0]  st_set;
  logic [1:0]  rd_cnt_reg;
  logic [31:0] ph_cnt_reg;
  logic        vbus_s;
  logic        dp_s;
  logic        dn_s;
  logic        vbus_d_reg;
  logic        vbus_ok;
  logic        phase_end;
  logic        wr_adr;
  logic        wr_dat;
  logic        rd_dat;
  logic        start_rd;
  usb_front_pkg::seq_state_t state_reg;

  line_sync3 u_sync_vbus (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
                          .async_i(vbus_i), .level_o(vbus_s));
  line_sync3 u_sync_dp   (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
                          .async_i(dp_i), .level_o(dp_s));
  line_sync3 u_sync_dn   (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
                          .async_i(dn_i), .level_o(dn_s));

  assign vbus_ok = cf_reg[usb_front_pkg::CF_VBUS_SENSE_BIT] ? vbus_s : 1'b1;

  assign wr_adr = sfr_wr_i && (sfr_addr_i == usb_front_pkg::ADDR_INDIRECT_CORE_ADDRESS);
  assign wr_dat = sfr_wr_i && (sfr_addr_i == usb_front_pkg::ADDR_INDIRECT_CORE_DATA);
  assign rd_dat = sfr_rd_i && (sfr_addr_i == usb_front_pkg::ADDR_INDIRECT_CORE_DATA);
  assign start_rd = (wr_adr && sfr_wdata_i[usb_front_pkg::ADR_BUSY_BIT])
                  || (rd_dat && auto_reg);

  // transceiver control register
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      xcn_reg <= usb_front_pkg::XCN_RESET;
    end else if (sfr_wr_i && sfr_addr_i == usb_front_pkg::ADDR_TRANSCEIVER_CONTROL) begin
      xcn_reg <= sfr_wdata_i[7:3];
    end
  end

  always_comb begin
    pullup_dp_o = xcn_reg[4] && vbus_ok && xcn_reg[2];
    pullup_dn_o = xcn_reg[4] && vbus_ok && !xcn_reg[2];
  end
  assign full_speed_o   = xcn_reg[2];
  assign xcvr_suspend_o = !xcn_reg[3];

  always_comb begin
    dp_oe_o = 1'b1;
    dn_oe_o = 1'b1;
    dp_o    = 1'b0;
    dn_o    = 1'b0;
    case (xcn_reg[1:0])
      usb_front_pkg::TEST_DIFF1: begin
        dp_o = 1'b1;
      end
      usb_front_pkg::TEST_DIFF0: begin
        dn_o = 1'b1;
      end
      usb_front_pkg::TEST_SE0: begin
      end
      default: begin
        dp_oe_o = 1'b0;
        dn_oe_o = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      adr_reg  <= usb_front_pkg::ADR_RESET;
      auto_reg <= 1'b0;
    end else if (wr_adr) begin
      adr_reg  <= sfr_wdata_i[5:0];
      auto_reg <= sfr_wdata_i[usb_front_pkg::ADR_AUTO_BIT];
    end
  end
  assign core_addr_o = adr_reg;

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      busy_reg   <= 1'b0;
      rd_cnt_reg <= 2'h0;
    end else if (start_rd) begin
      busy_reg   <= 1'b1;
      rd_cnt_reg <= 2'(usb_front_pkg::CORE_READ_CYCLES);
    end else if (busy_reg) begin
      rd_cnt_reg <= rd_cnt_reg - 2'h1;
      if (rd_cnt_reg == 2'h1) begin
        busy_reg <= 1'b0;
      end
    end
  end
  // strobe trails the address write by one cycle so the core sees the new address
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      core_rd_o <= 1'b0;
    end else begin
      core_rd_o <= start_rd;
    end
  end

  // data moves to and from core
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      data_reg <= usb_front_pkg::DATA_RESET;
    end else if (wr_dat) begin
      data_reg <= sfr_wdata_i;
    end else if (busy_reg && rd_cnt_reg == 2'h1) begin
      data_reg <= core_rdata_i;
    end
  end
  assign core_wr_o    = wr_dat;
  assign core_wdata_o = sfr_wdata_i;

  // charger config, enables cleared by the sequencer
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cf_reg <= usb_front_pkg::CF_RESET;
    end else begin
      if (sfr_wr_i && sfr_addr_i == usb_front_pkg::ADDR_CHARGER_DETECT_CONFIG) begin
        cf_reg <= sfr_wdata_i;
      end
      if (phase_end) begin
        case (state_reg)
          usb_front_pkg::SEQ_CONTACT: cf_reg[5:4] <= 2'h0;
          usb_front_pkg::SEQ_PRIMARY: cf_reg[usb_front_pkg::CF_PRI_BIT] <= 1'b0;
          usb_front_pkg::SEQ_SECONDARY: cf_reg[usb_front_pkg::CF_SEC_BIT] <= 1'b0;
          default: begin
          end
        endcase
      end
    end
  end
  assign dcd_timeout_en_o = (cf_reg[5:4] == usb_front_pkg::DCD_FULL);

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      seq_en_reg <= 1'b0;
    end else if (sfr_wr_i && sfr_addr_i == usb_front_pkg::ADDR_CHARGER_DETECT_CONTROL) begin
      seq_en_reg <= sfr_wdata_i[usb_front_pkg::CN_SEQ_BIT];
    end else if (state_reg != usb_front_pkg::SEQ_IDLE && phase_end
                 && state_reg == usb_front_pkg::SEQ_SECONDARY) begin
      seq_en_reg <= 1'b0;
    end
  end

  // phase timer: contact ends early on contact seen
  assign phase_end = (state_reg != usb_front_pkg::SEQ_IDLE) &&
                     ((ph_cnt_reg == 32'd1) ||
                      (state_reg == usb_front_pkg::SEQ_CONTACT && contact_seen_i));

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg  <= usb_front_pkg::SEQ_IDLE;
      ph_cnt_reg <= 32'd0;
    end else begin
      case (state_reg)
        usb_front_pkg::SEQ_IDLE: begin
          if (seq_en_reg && vbus_ok) begin
            ph_cnt_reg <= 32'(usb_front_pkg::PHASE_CYCLES);
            if (cf_reg[5:4] != 2'h0) begin
              state_reg <= usb_front_pkg::SEQ_CONTACT;
            end else if (cf_reg[usb_front_pkg::CF_PRI_BIT]) begin
              state_reg <= usb_front_pkg::SEQ_PRIMARY;
            end else if (cf_reg[usb_front_pkg::CF_SEC_BIT]) begin
              state_reg <= usb_front_pkg::SEQ_SECONDARY;
            end
          end
        end
        default: begin
          ph_cnt_reg <= ph_cnt_reg - 32'd1;
          if (!vbus_ok) begin
            state_reg <= usb_front_pkg::SEQ_IDLE;
          end else if (phase_end) begin
            ph_cnt_reg <= 32'(usb_front_pkg::PHASE_CYCLES);
            if (state_reg == usb_front_pkg::SEQ_CONTACT && cf_reg[usb_front_pkg::CF_PRI_BIT]) begin
              state_reg <= usb_front_pkg::SEQ_PRIMARY;
            end else if (state_reg != usb_front_pkg::SEQ_SECONDARY
                         && cf_reg[usb_front_pkg::CF_SEC_BIT]) begin
              state_reg <= usb_front_pkg::SEQ_SECONDARY;
            end else begin
              state_reg <= usb_front_pkg::SEQ_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      vbus_d_reg <= 1'b0;
    end else begin
      vbus_d_reg <= vbus_s;
    end
  end

  // status flag sets; set beats a write-one clear
  always_comb begin
    st_set = 8'h00;
    st_set[usb_front_pkg::ST_VBUS_ON]  = vbus_s && !vbus_d_reg;
    st_set[usb_front_pkg::ST_ERR_BIT]  = cf_reg[usb_front_pkg::CF_VBUS_SENSE_BIT] &&
                                         seq_en_reg && vbus_d_reg && !vbus_s;
    st_set[usb_front_pkg::ST_DCD_DONE] = phase_end && vbus_ok &&
                                         state_reg == usb_front_pkg::SEQ_CONTACT;
    st_set[usb_front_pkg::ST_PRI_DONE] = phase_end && vbus_ok &&
                                         state_reg == usb_front_pkg::SEQ_PRIMARY;
    st_set[usb_front_pkg::ST_SEC_DONE] = phase_end && vbus_ok &&
                                         state_reg == usb_front_pkg::SEQ_SECONDARY;
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_reg <= 8'h00;
    end else begin
      if (sfr_wr_i && sfr_addr_i == usb_front_pkg::ADDR_CHARGER_DETECT_STATUS) begin
        st_reg[7:3] <= (st_reg[7:3] & ~sfr_wdata_i[7:3]) | st_set[7:3];
      end else begin
        st_reg[7:3] <= st_reg[7:3] | st_set[7:3];
      end
      if (st_set[usb_front_pkg::ST_PRI_DONE]) begin
        st_reg[usb_front_pkg::ST_SDP_BIT] <= !primary_charger_i;
      end
      if (st_set[usb_front_pkg::ST_SEC_DONE]) begin
        st_reg[usb_front_pkg::ST_DCP_BIT] <= secondary_dedicated_i;
        st_reg[usb_front_pkg::ST_CDP_BIT] <= !secondary_dedicated_i;
      end
    end
  end

  assign irq_o = |st_reg[7:3];

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sfr_rdata_o <= 8'h00;
    end else begin
      case (sfr_addr_i)
        usb_front_pkg::ADDR_TRANSCEIVER_CONTROL:
          sfr_rdata_o <= {xcn_reg, dp_s && !dn_s && xcn_reg[3], dp_s, dn_s};
        usb_front_pkg::ADDR_INDIRECT_CORE_ADDRESS:
          sfr_rdata_o <= {busy_reg, auto_reg, adr_reg};
        usb_front_pkg::ADDR_INDIRECT_CORE_DATA:    sfr_rdata_o <= data_reg;
        usb_front_pkg::ADDR_CHARGER_DETECT_CONFIG:  sfr_rdata_o <= cf_reg;
        usb_front_pkg::ADDR_CHARGER_DETECT_CONTROL: sfr_rdata_o <= {7'h00, seq_en_reg};
        usb_front_pkg::ADDR_CHARGER_DETECT_STATUS:  sfr_rdata_o <= st_reg;
        default: sfr_rdata_o <= 8'h00;
      endcase
    end
  end

  AST_BUSY_CLEARS: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    start_rd |=> busy_reg ##1 busy_reg ##1 !busy_reg || start_rd)
    else $error("busy did not clear after read");
  AST_AUTO_RELAUNCH: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (rd_dat && auto_reg) |=> busy_reg && $stable(adr_reg))
    else $error("auto read did not relaunch");
  AST_PULLUP_VBUS: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (pullup_dp_o || pullup_dn_o) |-> vbus_ok && xcn_reg[4])
    else $error("pullup without vbus");
  AST_SPEED_LINE: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    pullup_dp_o |-> full_speed_o)
    else $error("pullup on wrong line");
  AST_SE0_DRIVE: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (xcn_reg[1:0] == usb_front_pkg::TEST_SE0) |-> dp_oe_o && dn_oe_o && !dp_o && !dn_o)
    else $error("se0 test drive wrong");
  AST_IDLE_GATE: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (state_reg == usb_front_pkg::SEQ_IDLE && !seq_en_reg) |=>
    state_reg == usb_front_pkg::SEQ_IDLE)
    else $error("sequencer left idle without enable");
  AST_PRI_DONE: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    st_set[usb_front_pkg::ST_PRI_DONE] |=>
    st_reg[usb_front_pkg::ST_PRI_DONE] && !cf_reg[usb_front_pkg::CF_PRI_BIT])
    else $error("primary completion not recorded");
  AST_ABORT: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (state_reg != usb_front_pkg::SEQ_IDLE && !vbus_ok) |=>
    state_reg == usb_front_pkg::SEQ_IDLE)
    else $error("phase not aborted on vbus loss");
  AST_IRQ: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (|st_set[7:3]) |=> irq_o)
    else $error("interrupt missing");
endmodule
`default_nettype wire

// File: tb/usb_port_model.sv
// Purpose: bus-side stand-in for a host, hub or charging port
// Assumes: host pull-downs hold a released data line low unless its pull-up is on
// Notes:   port kind is chosen by the bench; no analog timing modelled
`timescale 1ns/1ps
`default_nettype none
module usb_port_model (
  input  wire logic vbus_en_i,
  input  wire logic charging_port_i,
  input  wire logic dedicated_i,
  input  wire logic dp_drv_i,
  input  wire logic dp_oe_i,
  input  wire logic dn_drv_i,
  input  wire logic dn_oe_i,
  input  wire logic pullup_dp_i,
  input  wire logic pullup_dn_i,
  output logic      vbus_o,
  output logic      dp_o,
  output logic      dn_o,
  output logic      contact_o,
  output logic      primary_o,
  output logic      secondary_o
);
  assign vbus_o = vbus_en_i;
  // a driven line wins; otherwise the pull-up fights only the weak pull-down
  assign dp_o = dp_oe_i ? dp_drv_i : pullup_dp_i;
  assign dn_o = dn_oe_i ? dn_drv_i : pullup_dn_i;
  // data contact follows attach, so contact shows as soon as vbus is up
  assign contact_o = vbus_en_i;
  assign primary_o = vbus_en_i & charging_port_i;
  assign secondary_o = dedicated_i;
endmodule
`default_nettype wire

// File: tb/usb_charger_detect_phy_access_tb.sv
// Purpose: self-checking bench for the usb front-end block
// Assumes: host model on the bus side, small core register stand-in
// Notes:   primary and secondary phases run full length, so the run is some 20k cycles
`timescale 1ns/1ps
`default_nettype none
module usb_charger_detect_phy_access_tb;
  logic       ref_clk_i = 1'b0;
  logic       resetn_i = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic       sfr_wr = 1'b0;
  logic       sfr_rd = 1'b0;
  logic       vbus_en = 1'b0;
  logic       chg_port = 1'b0;
  logic       ded = 1'b0;
  logic [7:0] core_rdata = 8'h00;
  logic [7:0] rd_cnt = 8'h00;
  logic [7:0] wr_seen = 8'h00;
  logic [7:0] launches = 8'h00;
  logic [7:0] sfr_rdata, core_wdata, v;
  logic [5:0] core_addr;
  logic       vbus, dp, dn, contact, pri, sec, core_wr, core_rd;
  logic       dp_d, dp_oe, dn_d, dn_oe, pu_dp, pu_dn, susp, fs, dcd_to, irq;
  int         err_total = 0;
  int         n_compared = 0;

  usb_charger_detect_phy_access u_usb_charger_detect_phy_access (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .sfr_addr_i(sfr_addr),
    .sfr_wdata_i(sfr_wdata), .sfr_wr_i(sfr_wr), .sfr_rd_i(sfr_rd),
    .sfr_rdata_o(sfr_rdata), .vbus_i(vbus), .dp_i(dp), .dn_i(dn),
    .contact_seen_i(contact), .primary_charger_i(pri), .secondary_dedicated_i(sec),
    .dp_o(dp_d), .dp_oe_o(dp_oe), .dn_o(dn_d), .dn_oe_o(dn_oe),
    .pullup_dp_o(pu_dp), .pullup_dn_o(pu_dn), .xcvr_suspend_o(susp),
    .full_speed_o(fs), .dcd_timeout_en_o(dcd_to), .irq_o(irq),
    .core_addr_o(core_addr), .core_wdata_o(core_wdata), .core_wr_o(core_wr),
    .core_rd_o(core_rd), .core_rdata_i(core_rdata));

  usb_port_model u_usb_port_model (
    .vbus_en_i(vbus_en), .charging_port_i(chg_port), .dedicated_i(ded),
    .dp_drv_i(dp_d), .dp_oe_i(dp_oe), .dn_drv_i(dn_d), .dn_oe_i(dn_oe),
    .pullup_dp_i(pu_dp), .pullup_dn_i(pu_dn), .vbus_o(vbus), .dp_o(dp),
    .dn_o(dn), .contact_o(contact), .primary_o(pri), .secondary_o(sec));

  initial begin
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  // core stand-in: each launch answers with a fresh value, so a stale one shows
  always @(posedge ref_clk_i) begin
    if (core_rd === 1'b1) begin
      core_rdata <= rd_cnt ^ {2'b00, core_addr};
      rd_cnt     <= rd_cnt + 8'h01;
    end
    if (core_wr === 1'b1) begin
      wr_seen <= core_wdata ^ {2'b00, core_addr};
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_sfr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr    <= 1'b1;
    @(posedge ref_clk_i);
    sfr_wr <= 1'b0;
    #1;
  endtask

  task automatic rd_sfr(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    sfr_addr <= a;
    sfr_rd   <= 1'b1;
    @(posedge ref_clk_i);
    sfr_rd <= 1'b0;
    #1 d = sfr_rdata;
  endtask

  task automatic poll(input logic [7:0] a, input int b, input logic lvl, output logic [7:0] d);
    int n;
    n = 0;
    rd_sfr(a, d);
    while (d[b] !== lvl && n < 3000) begin
      rd_sfr(a, d);
      n++;
    end
    if (d[b] !== lvl) begin
      err_total++;
      $display("poll limit reached at %0t", $time);
    end
  endtask

  task automatic t_reset;
    rd_sfr(8'hae, v); chk(v, 8'h00);
    rd_sfr(8'haf, v); chk(v, 8'h00);
    rd_sfr(8'hb3, v); chk(v, 8'h00);
    rd_sfr(8'hb0, v); chk(v, 8'h00);
    chk({4'h0, susp, dp_oe, dn_oe, irq}, 8'h08);
    $display("test reset finished");
  endtask

  task automatic t_xcvr;
    logic [1:0] m, lv;
    @(posedge ref_clk_i) vbus_en <= 1'b1;
    wr_sfr(8'hb3, 8'he0);
    repeat (8) @(posedge ref_clk_i);
    chk({4'h0, pu_dp, pu_dn, fs, susp}, 8'h0a);
    rd_sfr(8'hb3, v); chk(v, 8'he6);
    wr_sfr(8'hb3, 8'hc0);
    repeat (8) @(posedge ref_clk_i);
    chk({4'h0, pu_dp, pu_dn, fs, susp}, 8'h04);
    rd_sfr(8'hb3, v); chk(v, 8'hc1);
    for (int i = 0; i < 4; i++) begin
      m = i[1:0];
      lv = (m == 2'h1) ? 2'b10 : (m == 2'h2) ? 2'b01 : 2'b00;
      wr_sfr(8'hb3, {3'b010, m, 3'b000});
      repeat (8) @(posedge ref_clk_i);
      chk({4'h0, dp_oe, dn_oe, dp_d & dp_oe, dn_d & dn_oe}, {4'h0, {2{m != 2'h0}}, lv});
      rd_sfr(8'hb3, v); chk(v, {3'b010, m, lv[1] & ~lv[0], lv});
    end
    wr_sfr(8'hb3, 8'he0);
    // without sensing vbus counts as present, so sensing goes on first
    wr_sfr(8'hb4, 8'h80);
    @(posedge ref_clk_i) vbus_en <= 1'b0;
    repeat (8) @(posedge ref_clk_i);
    chk({6'h00, pu_dp, pu_dn}, 8'h00);
    @(posedge ref_clk_i) vbus_en <= 1'b1;
    repeat (8) @(posedge ref_clk_i);
    chk({6'h00, pu_dp, pu_dn}, 8'h02);
    $display("test transceiver finished");
  endtask

  task automatic t_indirect;
    wr_sfr(8'hae, 8'h85);
    launches = launches + 8'h01;
    @(posedge ref_clk_i);
    #1 chk(sfr_rdata, 8'h85);
    poll(8'hae, 7, 1'b0, v); chk(v, 8'h05);
    rd_sfr(8'haf, v); chk(v, (launches - 8'h01) ^ 8'h05);
    chk(rd_cnt, launches);
    wr_sfr(8'hae, 8'he1);
    launches = launches + 8'h01;
    poll(8'hae, 7, 1'b0, v);
    for (int i = 0; i < 3; i++) begin
      rd_sfr(8'haf, v); chk(v, (launches - 8'h01) ^ 8'h21);
      launches = launches + 8'h01;
      poll(8'hae, 7, 1'b0, v); chk(v, 8'h61);
    end
    chk(rd_cnt, launches);
    wr_sfr(8'hae, 8'h21);
    rd_sfr(8'haf, v);
    repeat (4) @(posedge ref_clk_i);
    chk(rd_cnt, launches);
    wr_sfr(8'haf, 8'h3c);
    repeat (2) @(posedge ref_clk_i);
    chk(wr_seen, 8'h1d);
    $display("test indirect finished");
  endtask

  task automatic t_charger;
    wr_sfr(8'hb6, 8'hf8);
    wr_sfr(8'hb4, 8'hb8);
    chk({7'h00, dcd_to}, 8'h01);
    // sequence enable still clear: nothing may run for a whole phase length
    repeat (4100) @(posedge ref_clk_i);
    rd_sfr(8'hb6, v); chk(v & 8'h38, 8'h00);
    wr_sfr(8'hb5, 8'h01);
    poll(8'hb6, 4, 1'b1, v); chk(v & 8'hbc, 8'h34);
    chk({7'h00, irq}, 8'h01);
    rd_sfr(8'hb4, v); chk(v, 8'h80);
    wr_sfr(8'hb6, 8'hf8);
    chk({7'h00, irq}, 8'h00);
    for (int i = 0; i < 2; i++) begin
      @(posedge ref_clk_i);
      ded      <= (i == 0);
      chg_port <= 1'b1;
      wr_sfr(8'hb4, 8'h84);
      wr_sfr(8'hb5, 8'h01);
      poll(8'hb6, 3, 1'b1, v); chk(v & 8'h3b, (i == 0) ? 8'h0a : 8'h09);
      rd_sfr(8'hb5, v); chk(v, 8'h00);
      wr_sfr(8'hb6, 8'hf8);
    end
    $display("test charger finished");
  endtask

  task automatic t_abort;
    wr_sfr(8'hb4, 8'h88);
    wr_sfr(8'hb5, 8'h01);
    repeat (200) @(posedge ref_clk_i);
    vbus_en <= 1'b0;
    repeat (20) @(posedge ref_clk_i);
    rd_sfr(8'hb6, v); chk(v & 8'h90, 8'h80);
    chk({7'h00, irq}, 8'h01);
    wr_sfr(8'hb6, 8'hf8);
    // sensing off with vbus absent: the phase must still run
    wr_sfr(8'hb4, 8'h08);
    wr_sfr(8'hb5, 8'h01);
    poll(8'hb6, 4, 1'b1, v); chk(v & 8'h90, 8'h10);
    wr_sfr(8'hb6, 8'hf8);
    @(posedge ref_clk_i) vbus_en <= 1'b1;
    repeat (10) @(posedge ref_clk_i);
    rd_sfr(8'hb6, v); chk(v & 8'h40, 8'h40);
    $display("test abort finished");
  endtask

  task automatic end_sim;
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    t_reset;
    t_xcvr;
    t_indirect;
    t_charger;
    t_abort;
    end_sim;
  end

  // the tests need about 20k cycles; three times that means a hang
  initial begin
    repeat (60000) @(posedge ref_clk_i);
    err_total++;
    $display("watchdog expired at %0t", $time);
    end_sim;
  end
endmodule
`default_nettype wire
